// >>> rtl/sdc_drive_ctrl.sv
// Drive control register, configuration decode, step handling and SPI response
`timescale 1ns/1ps
module sdc_drive_ctrl (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       sck,
	input  wire logic       chip_select_n,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	input  wire logic       step_in,
	input  wire logic       dir_in,
	input  wire logic [9:0] microstep_position,
	input  wire logic [9:0] load_detect_value,
	input  wire logic [4:0] adaptive_current_level,
	input  wire logic       standstill_flag,
	input  wire logic       open_load_b_flag,
	input  wire logic       open_load_a_flag,
	input  wire logic       short_ground_b_flag,
	input  wire logic       short_ground_a_flag,
	input  wire logic       overtemp_warning_flag,
	input  wire logic       overtemp_shutdown_flag,
	input  wire logic       load_threshold_flag,
	output logic            stepdir_disable,
	output logic [1:0]      readback_select,
	output logic            coil_a_polarity,
	output logic [7:0]      coil_a_magnitude,
	output logic            coil_b_polarity,
	output logic [7:0]      coil_b_magnitude,
	output logic            step_interpolate_enable,
	output logic            double_edge_enable,
	output logic [3:0]      microstep_resolution,
	output logic [8:0]      microsteps_per_quarter,
	output logic            microstep_pulse,
	output logic            microstep_dir
);
	import sdc_pkg::*;

	logic [4:0] sync_q, sync_r, sync_f;
	sdc_sync #(.W(5)) u_sync (
		.mclk     (mclk),
		.rstn     (rstn),
		// Select enters inverted so its reset value matches an idle bus
		.async_in ({dir_in, step_in, sdi, ~chip_select_n, sck}),
		.sync_out (sync_q),
		.rise     (sync_r),
		.fall     (sync_f)
	);
	wire sck_rise = sync_r[0];
	wire sck_fall = sync_f[0];
	wire cs_rise  = sync_f[1];
	wire cs_fall  = sync_r[1];
	wire cs_low   = sync_q[1];
	wire sdi_q    = sync_q[2];
	wire step_r   = sync_r[3];
	wire step_f   = sync_f[3];
	wire dir_q    = sync_q[4];

	sdc_state_e        st_reg, st_next;
	logic [WORD_W-1:0] shin_reg, shin_next;
	logic [WORD_W-1:0] shout_reg, shout_next;
	logic [WORD_W-1:0] ctrl_reg, ctrl_next;
	logic [WORD_W-1:0] conf_reg, conf_next;
	logic              mode_reg, mode_next;
	logic [WORD_W-1:0] resp;

	always_comb begin
		resp = '0;
		unique case (conf_reg[READBACK_SEL_HI:READBACK_SEL_LO])
			READBACK_POSITION: resp[WORD_W-1:RESP_UPPER_LO] = microstep_position;
			READBACK_LOAD:     resp[WORD_W-1:RESP_UPPER_LO] = load_detect_value;
			READBACK_LOAD_CUR: resp[WORD_W-1:RESP_UPPER_LO] = {load_detect_value[9:5],
				adaptive_current_level};
			default:           resp[WORD_W-1:RESP_UPPER_LO] = '0;
		endcase
		resp[RESP_FLAGS_HI:0] = {standstill_flag, open_load_b_flag, open_load_a_flag,
			short_ground_b_flag,
			short_ground_a_flag, overtemp_warning_flag, overtemp_shutdown_flag,
			load_threshold_flag};
	end

	always_comb begin
		st_next    = st_reg;
		shin_next  = shin_reg;
		shout_next = shout_reg;
		ctrl_next  = ctrl_reg;
		conf_next  = conf_reg;
		mode_next  = mode_reg;
		unique case (st_reg)
			SDC_IDLE: begin
				if (cs_fall) begin
					st_next    = SDC_SHIFT;
					shout_next = resp;
					// A short frame never reuses bits of the previous one
					shin_next  = '0;
				end
			end
			SDC_SHIFT: begin
				// Extra leading bits fall off the top of the shift register
				if (sck_rise)
					shin_next = {shin_reg[WORD_W-2:0], sdi_q};
				if (sck_fall)
					shout_next = {shout_reg[WORD_W-2:0], 1'b0};
				if (cs_rise)
					st_next = SDC_LATCH;
			end
			SDC_LATCH: begin
				st_next = SDC_IDLE;
				if (shin_reg[ADDR_HI:ADDR_LO] == ADDR_DRIVE_CTRL) begin
					ctrl_next = shin_reg;
					mode_next = conf_reg[STEPDIR_OFF_BIT];
				end else if (shin_reg[ADDR_HI:ADDR_LO] == ADDR_DRIVER_CONF
						&& shin_reg[CONF_BIT17]) begin
					conf_next = shin_reg;
				end
			end
			default: st_next = SDC_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_reg    <= SDC_IDLE;
			shin_reg  <= '0;
			shout_reg <= '0;
			ctrl_reg  <= DRIVE_CTRL_RST;
			conf_reg  <= DRIVER_CONF_RST;
			mode_reg  <= 1'b0;
		end else begin
			st_reg    <= st_next;
			shin_reg  <= shin_next;
			shout_reg <= shout_next;
			ctrl_reg  <= ctrl_next;
			conf_reg  <= conf_next;
			mode_reg  <= mode_next;
		end
	end

	assign sdo_oe          = cs_low;
	assign sdo             = shout_reg[WORD_W-1];
	assign stepdir_disable = conf_reg[STEPDIR_OFF_BIT];
	assign readback_select = conf_reg[READBACK_SEL_HI:READBACK_SEL_LO];

	// Decoded fields, zero in whichever layout is not active
	logic       pol_a_reg, pol_a_next;
	logic [7:0] mag_a_reg, mag_a_next;
	logic       pol_b_reg, pol_b_next;
	logic [7:0] mag_b_reg, mag_b_next;
	logic       interp_reg, interp_next;
	logic       dual_edge_reg, dual_edge_next;
	logic [3:0] resol_reg, resol_next;
	logic [8:0] quarter_reg, quarter_next;

	always_comb begin
		pol_a_next     = 1'b0;
		mag_a_next     = '0;
		pol_b_next     = 1'b0;
		mag_b_next     = '0;
		interp_next    = 1'b0;
		dual_edge_next = 1'b0;
		resol_next     = '0;
		quarter_next   = '0;
		if (mode_reg) begin
			pol_a_next = ctrl_reg[COIL_A_POL_BIT];
			mag_a_next = ctrl_reg[COIL_A_MAG_HI:COIL_A_MAG_LO];
			pol_b_next = ctrl_reg[COIL_B_POL_BIT];
			mag_b_next = ctrl_reg[COIL_B_MAG_HI:COIL_B_MAG_LO];
		end else begin
			interp_next    = ctrl_reg[INTERP_BIT];
			dual_edge_next = ctrl_reg[DOUBLE_EDGE_BIT];
			resol_next     = ctrl_reg[RESOLUTION_HI:RESOLUTION_LO];
			// Codes above eight are undefined; treated as full step
			if (ctrl_reg[RESOLUTION_HI:RESOLUTION_LO] <= RESOLUTION_MAX)
				quarter_next = 9'h100 >> ctrl_reg[RESOLUTION_HI:RESOLUTION_LO];
			else
				quarter_next = 9'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pol_a_reg     <= 1'b0;
			mag_a_reg     <= 8'h00;
			pol_b_reg     <= 1'b0;
			mag_b_reg     <= 8'h00;
			interp_reg    <= 1'b0;
			dual_edge_reg <= 1'b0;
			resol_reg     <= 4'h0;
			quarter_reg   <= 9'h000;
		end else begin
			pol_a_reg     <= pol_a_next;
			mag_a_reg     <= mag_a_next;
			pol_b_reg     <= pol_b_next;
			mag_b_reg     <= mag_b_next;
			interp_reg    <= interp_next;
			dual_edge_reg <= dual_edge_next;
			resol_reg     <= resol_next;
			quarter_reg   <= quarter_next;
		end
	end

	assign coil_a_polarity         = pol_a_reg;
	assign coil_a_magnitude        = mag_a_reg;
	assign coil_b_polarity         = pol_b_reg;
	assign coil_b_magnitude        = mag_b_reg;
	assign step_interpolate_enable = interp_reg;
	assign double_edge_enable      = dual_edge_reg;
	assign microstep_resolution    = resol_reg;
	assign microsteps_per_quarter  = quarter_reg;

	// Step edges and interpolation burst generator
	logic       step_evt;
	logic [4:0] burst_reg, burst_next;
	logic [7:0] gap_reg, gap_next;
	logic       pulse_reg, pulse_next;
	logic       pdir_reg, pdir_next;
	assign step_evt = ~mode_reg & (step_r | (ctrl_reg[DOUBLE_EDGE_BIT] & step_f));

	always_comb begin
		burst_next = burst_reg;
		gap_next   = gap_reg;
		pulse_next = 1'b0;
		pdir_next  = pdir_reg;
		if (step_evt) begin
			pulse_next = 1'b1;
			pdir_next  = dir_q;
			// A new step restarts any burst still running
			burst_next = ctrl_reg[INTERP_BIT] ? 5'(INTERP_MULT - 1) : 5'h00;
			gap_next   = 8'(SUBSTEP_CYC);
		end else if (burst_reg != 5'h00) begin
			if (gap_reg == 8'h01) begin
				pulse_next = 1'b1;
				burst_next = burst_reg - 5'h01;
				gap_next   = 8'(SUBSTEP_CYC);
			end else begin
				gap_next = gap_reg - 8'h01;
			end
		end
		// A switch to direct mode also drops a sub-step already due
		if (mode_reg) begin
			burst_next = 5'h00;
			pulse_next = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			burst_reg <= 5'h00;
			gap_reg   <= 8'h00;
			pulse_reg <= 1'b0;
			pdir_reg  <= 1'b0;
		end else begin
			burst_reg <= burst_next;
			gap_reg   <= gap_next;
			pulse_reg <= pulse_next;
			pdir_reg  <= pdir_next;
		end
	end

	assign microstep_pulse = pulse_reg;
	assign microstep_dir   = pdir_reg;
endmodule : sdc_drive_ctrl

// >>> rtl/sdc_pkg.sv
// Constants and types for the stepper drive control and readback block
// Operation
// - The readback select field of the driver configuration register picks the response layout.
// - Response bits 19..10 carry microstep position (%00), load value (%01) or load MSBs plus current level (%10).
// - Response bits 7..0 carry standstill, open load B/A, short B/A, overtemp warning, shutdown, load threshold.
// - The drive control register is decoded in one of two layouts chosen by the stepdir disable bit as it stood at the last drive control write.
// - With stepdir disabled, step and direction inputs are ignored and coil currents come from the register.
// - With stepdir enabled, motion comes from the step and direction inputs and the register configures them.
// - In direct mode bit 17 is the coil A current sign, 0 meaning out1 to out2.
// - In direct mode bit 8 is the coil B current sign, 0 meaning out1 to out2.
// - In direct mode bits 16..9 hold coil A magnitude and bits 7..0 coil B magnitude.
// - In step mode bit 9 enables interpolation, each step pulse becoming 16 microsteps.
// - In step mode bit 8 makes both step edges active instead of only the rising one.
// - Bits 19 and 18 of a write select the target register, both zero for drive control.
// - On the rising chip select edge only the last 20 bits shifted in are latched.
package sdc_pkg;
	localparam int          WORD_W        = 20;
	localparam logic [1:0]  ADDR_DRIVE_CTRL   = 2'h0;
	localparam logic [1:0]  ADDR_DRIVER_CONF  = 2'h3;
	localparam int          ADDR_HI           = 19;
	localparam int          ADDR_LO           = 18;
	localparam int          CONF_BIT17        = 17;
	localparam int          COIL_A_POL_BIT    = 17;
	localparam int          COIL_A_MAG_HI     = 16;
	localparam int          COIL_A_MAG_LO     = 9;
	localparam int          COIL_B_POL_BIT    = 8;
	localparam int          COIL_B_MAG_HI     = 7;
	localparam int          COIL_B_MAG_LO     = 0;
	localparam int          INTERP_BIT        = 9;
	localparam int          DOUBLE_EDGE_BIT   = 8;
	localparam int          RESOLUTION_HI     = 3;
	localparam int          RESOLUTION_LO     = 0;
	localparam int          STEPDIR_OFF_BIT   = 7;
	localparam int          READBACK_SEL_HI   = 5;
	localparam int          READBACK_SEL_LO   = 4;
	localparam int          RESP_UPPER_LO     = 10;
	localparam int          RESP_FLAGS_HI     = 7;
	localparam logic [1:0]  READBACK_POSITION = 2'h0;
	localparam logic [1:0]  READBACK_LOAD     = 2'h1;
	localparam logic [1:0]  READBACK_LOAD_CUR = 2'h2;
	localparam logic [19:0] DRIVE_CTRL_RST    = 20'h00000;
	localparam logic [19:0] DRIVER_CONF_RST   = 20'he0000;
	localparam int          INTERP_MULT       = 16;
	localparam logic [3:0]  RESOLUTION_MAX    = 4'h8;
	// Sub-step spacing in clock cycles; a whole burst fits between slow steps
	localparam int          SUBSTEP_CYC       = 8;
	typedef enum logic [1:0] {
		SDC_IDLE  = 2'b00,
		SDC_SHIFT = 2'b01,
		SDC_LATCH = 2'b11
	} sdc_state_e;
endpackage : sdc_pkg

// >>> rtl/sdc_sync.sv
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module sdc_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, st_reg;
	logic [W-1:0] s1_next, s2_next, s3_next, st_next;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				s1_next[i] = async_in[i];
				s2_next[i] = s1_reg[i];
				s3_next[i] = s2_reg[i];
				// Change counts only once stages two and three agree
				st_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : st_reg[i];
			end
			assign rise[i] = st_next[i] & ~st_reg[i];
			assign fall[i] = ~st_next[i] & st_reg[i];
		end
	endgenerate
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			st_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			st_reg <= st_next;
		end
	end
	assign sync_out = st_reg;
endmodule : sdc_sync

// >>> sim/sdc_drive_ctrl_monitor.sv
// Port checker for the drive control block
`timescale 1ns/1ps
module sdc_drive_ctrl_monitor (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       chip_select_n,
	input wire logic       sdo_oe,
	input wire logic       stepdir_disable,
	input wire logic       coil_a_polarity,
	input wire logic [7:0] coil_a_magnitude,
	input wire logic       coil_b_polarity,
	input wire logic [7:0] coil_b_magnitude,
	input wire logic       step_interpolate_enable,
	input wire logic       double_edge_enable,
	input wire logic [3:0] microstep_resolution,
	input wire logic [8:0] microsteps_per_quarter,
	input wire logic       microstep_pulse
);
	logic [17:0] drv;
	logic [5:0]  stp;
	assign drv = {coil_a_polarity, coil_a_magnitude, coil_b_polarity, coil_b_magnitude};
	assign stp = {step_interpolate_enable, double_edge_enable, microstep_resolution};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_mode_exclusive:
		assert property (!(|drv && |{stp, microsteps_per_quarter})) else $error("Both layouts");
	a_microstep_resolution_table:
		assert property (|microsteps_per_quarter |-> microsteps_per_quarter ==
			(microstep_resolution > 4'h8 ? 9'h001 : 9'h100 >> microstep_resolution))
			else $error("Bad quarter count");
	a_pulse_single:
		assert property (microstep_pulse |=> !microstep_pulse) else $error("Long pulse");
	a_interp_gap:
		assert property (microstep_pulse && step_interpolate_enable |=> !microstep_pulse [*7])
			else $error("Substeps too close");
	a_direct_no_pulse:
		assert property (|drv |-> !microstep_pulse) else $error("Step in direct mode");
	a_oe_on:
		assert property ($fell(chip_select_n) |-> ##[2:6] sdo_oe) else $error("No drive");
	a_oe_off:
		assert property ($rose(chip_select_n) |-> ##[2:6] !sdo_oe) else $error("No release");
	a_latch_cs:
		assert property ($changed({drv, stp}) |-> $past(chip_select_n, 3)) else $error("Early");
	a_mode_hold:
		assert property ($changed(stepdir_disable) |-> $stable({drv, stp})) else $error("Moved");
	c_interp: cover property (microstep_pulse && step_interpolate_enable);
	c_direct: cover property (|drv);
	c_release: cover property ($fell(sdo_oe));
endmodule : sdc_drive_ctrl_monitor
bind sdc_drive_ctrl sdc_drive_ctrl_monitor u_sdc_drive_ctrl_monitor (
	.mclk                    (mclk),
	.rstn                    (rstn),
	.chip_select_n           (chip_select_n),
	.sdo_oe                  (sdo_oe),
	.stepdir_disable         (stepdir_disable),
	.coil_a_polarity         (coil_a_polarity),
	.coil_a_magnitude        (coil_a_magnitude),
	.coil_b_polarity         (coil_b_polarity),
	.coil_b_magnitude        (coil_b_magnitude),
	.step_interpolate_enable (step_interpolate_enable),
	.double_edge_enable      (double_edge_enable),
	.microstep_resolution    (microstep_resolution),
	.microsteps_per_quarter  (microsteps_per_quarter),
	.microstep_pulse         (microstep_pulse)
);

// >>> sim/sdc_host_model.sv
// SPI master and step source acting as host and motion controller
`timescale 1ns/1ps
module sdc_host_model (
	output logic        sck,
	output logic        chip_select_n,
	output logic        sdi,
	output logic        step_in,
	output logic        dir_in,
	input  wire logic   sdo,
	input  wire logic   sdo_oe,
	output logic [19:0] rd_word,
	output logic        rd_done
);
	initial begin
		{sck, sdi, step_in, dir_in, rd_done} = 5'h02;
		chip_select_n = 1'b1;
	end
	// Junk prefix checks that only the last 20 bits count
	task automatic xfer(input logic [19:0] w, input logic [3:0] junk, input bit lead);
		logic [23:0] s;
		s = {junk, w};
		chip_select_n = 1'b0;
		#400;
		for (int i = lead ? 23 : 19; i >= 0; i--) begin
			sdi = s[i];
			#100;
			sck = 1'b1;
			#100;
			if (i >= (lead ? 4 : 0))
				// An undriven line reads inverted so a late enable shows up
				rd_word = {rd_word[18:0], sdo_oe ? sdo : ~sdo};
			sck = 1'b0;
		end
		#100;
		chip_select_n = 1'b1;
		// Released line flips so a stale bit never looks valid
		sdi = ~sdi;
		#400;
		rd_done = ~rd_done;
	endtask : xfer
	task automatic steps(input int n, input logic d);
		dir_in = d;
		repeat (n) begin
			#4000;
			step_in = ~step_in;
		end
	endtask : steps
endmodule : sdc_host_model

// >>> sim/stepper_drive_control_readback_test.sv
// Self-checking bench for the drive control and readback block
`timescale 1ns/1ps
module stepper_drive_control_readback_test;
	import sdc_pkg::*;
	logic        mclk, rstn, sdo, sdo_oe, stepdir_disable, coil_a_polarity, coil_b_polarity, d;
	logic        sck, chip_select_n, sdi, step_in, dir_in, rd_done, microstep_pulse, microstep_dir;
	logic        step_interpolate_enable, double_edge_enable;
	logic [1:0]  readback_select, sel_now;
	logic [3:0]  microstep_resolution;
	logic [4:0]  adaptive_current_level;
	logic [7:0]  coil_a_magnitude, coil_b_magnitude, flags;
	logic [8:0]  microsteps_per_quarter;
	logic [9:0]  microstep_position, load_detect_value;
	logic [19:0] rd_word, w;
	logic [19:0] exp_q[$];
	wire         standstill_flag, open_load_b_flag, open_load_a_flag, short_ground_b_flag;
	wire         short_ground_a_flag, overtemp_warning_flag, overtemp_shutdown_flag;
	wire         load_threshold_flag;
	int          num_errors, check_count, pcnt, p0, cycles;
	wire [19:0]  drv_now = {2'b00, coil_a_polarity, coil_a_magnitude, coil_b_polarity,
		coil_b_magnitude};
	wire [19:0]  stp_now = {10'h0, step_interpolate_enable, double_edge_enable, 4'h0,
		microstep_resolution};
	assign {standstill_flag, open_load_b_flag, open_load_a_flag, short_ground_b_flag,
		short_ground_a_flag, overtemp_warning_flag, overtemp_shutdown_flag,
		load_threshold_flag} = flags;
	sdc_drive_ctrl u_sdc_drive_ctrl (
		.mclk(mclk), .rstn(rstn), .sck(sck), .chip_select_n(chip_select_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .step_in(step_in), .dir_in(dir_in),
		.microstep_position(microstep_position), .load_detect_value(load_detect_value),
		.adaptive_current_level(adaptive_current_level), .standstill_flag(standstill_flag),
		.open_load_b_flag(open_load_b_flag), .open_load_a_flag(open_load_a_flag),
		.short_ground_b_flag(short_ground_b_flag), .short_ground_a_flag(short_ground_a_flag),
		.overtemp_warning_flag(overtemp_warning_flag),
		.overtemp_shutdown_flag(overtemp_shutdown_flag),
		.load_threshold_flag(load_threshold_flag), .stepdir_disable(stepdir_disable),
		.readback_select(readback_select), .coil_a_polarity(coil_a_polarity),
		.coil_a_magnitude(coil_a_magnitude), .coil_b_polarity(coil_b_polarity),
		.coil_b_magnitude(coil_b_magnitude), .step_interpolate_enable(step_interpolate_enable),
		.double_edge_enable(double_edge_enable), .microstep_resolution(microstep_resolution),
		.microsteps_per_quarter(microsteps_per_quarter), .microstep_pulse(microstep_pulse),
		.microstep_dir(microstep_dir)
	);
	sdc_host_model u_sdc_host_model (
		.sck(sck), .chip_select_n(chip_select_n), .sdi(sdi), .step_in(step_in),
		.dir_in(dir_in), .sdo(sdo), .sdo_oe(sdo_oe), .rd_word(rd_word), .rd_done(rd_done)
	);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (microstep_pulse === 1'b1)
			pcnt <= pcnt + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	always @(rd_done)
		if (rstn === 1'b1)
			check(rd_word, exp_q.pop_front());
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [19:0] resp();
		logic [9:0] hi;
		hi = sel_now == READBACK_POSITION ? microstep_position :
			sel_now == READBACK_LOAD ? load_detect_value :
			sel_now == READBACK_LOAD_CUR ? {load_detect_value[9:5], adaptive_current_level} :
			10'h000;
		return {hi, 2'b00, flags};
	endfunction : resp
	task automatic send(input logic [19:0] v, input bit lead);
		@(posedge mclk);
		#2;
		{microstep_position, load_detect_value, adaptive_current_level, flags} =
			33'({$urandom(), $urandom()});
		exp_q.push_back(resp());
		u_sdc_host_model.xfer(v, 4'hc, lead);
	endtask : send
	task automatic end_sim();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		rstn = 1'b0;
		{microstep_position, load_detect_value, adaptive_current_level, flags} = '0;
		sel_now = 2'h0;
		void'($urandom(32'h3b64));
		repeat (16) @(posedge mclk);
		#2;
		rstn = 1'b1;
		check({sdo_oe, stepdir_disable, readback_select, microstep_pulse, microstep_dir, 4'h0,
			stp_now[9:0]}, 20'h0);
		check(drv_now, 20'h0);
		repeat (4) @(posedge mclk);
		for (int s = 0; s < 4; s++) begin
			send(DRIVER_CONF_RST | {12'h0, s == 3, 1'b0, 2'(s + 1), 4'h0}, 1'b0);
			sel_now = 2'(s + 1);
			check(20'({stepdir_disable, readback_select}), 20'({s == 3, sel_now}));
		end
		// Magnitudes kept to 248 so headroom stays for offset
		for (int i = 0; i < 3; i++) begin
			w = {2'b00, 1'($urandom), 8'($urandom_range(248)), 1'($urandom),
				8'($urandom_range(248))};
			send(w, i[0]);
			p0 = pcnt;
			u_sdc_host_model.steps(2, 1'b1);
			check(drv_now, w);
			check(20'({10'(pcnt - p0), stp_now[9:0]}), 20'h0);
		end
		send({2'b10, 18'($urandom)}, 1'b1);
		check(drv_now, w);
		send(DRIVER_CONF_RST, 1'b0);
		check(drv_now, w);
		for (int m = 0; m < 10; m++) begin
			w = {10'h0, m[0], m[1], 4'h0, 4'(m)};
			d = 1'($urandom);
			send(w, 1'b0);
			p0 = pcnt;
			u_sdc_host_model.steps(4, d);
			#4000;
			check(stp_now, w);
			check(drv_now, 20'h0);
			check(20'(microsteps_per_quarter), m > 8 ? 20'h00001 : 20'(9'h100 >> m));
			check(20'(pcnt - p0), (m[1] ? 20'd4 : 20'd2) * (m[0] ? 20'd16 : 20'd1));
			check(20'(microstep_dir), 20'(d));
		end
		end_sim();
	end
endmodule : stepper_drive_control_readback_test
